// [src/sclk_divider_ctl.sv]
`timescale 1ns/10ps
module sclk_divider_ctl
	import sclk_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register access
	input sclk_reg_req_t regReq,
	output logic [7:0] regRdata,
	// clock enables
	output logic cpuClkEn,
	output logic btTickEn,
	// basic timer and watchdog
	output logic [BT_CNT_WIDTH-1:0] btCount,
	output logic wdtEnable
);
	logic [7:0] btCtl_r, btCtl_nxt;
	logic [1:0] cpuSel_r, cpuSel_nxt;
	logic oscWake_r, oscWake_nxt;
	logic [DIV_WIDTH-1:0] div_r, div_nxt;
	logic [BT_CNT_WIDTH-1:0] btCnt_r, btCnt_nxt;
	logic cpuEn_r, cpuEn_nxt;
	logic btEn_r, btEn_nxt;
	logic wdtEn_r, wdtEn_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	function automatic logic divTap(input logic [DIV_WIDTH-1:0] d, input int lsb);
		logic [DIV_WIDTH-1:0] m;
		m = DIV_WIDTH'((1 << lsb) - 1);
		divTap = ((d & m) == m);
	endfunction

	logic btWr, ckWr;
	assign btWr = regReq.wr && (regReq.addr == BASIC_TIMER_CONTROL_ADDR);
	assign ckWr = regReq.wr && (regReq.addr == SYSTEM_CLOCK_CONTROL_ADDR);

	always_comb begin
		btCtl_nxt = btCtl_r;
		cpuSel_nxt = cpuSel_r;
		oscWake_nxt = oscWake_r;
		div_nxt = div_r + 1'b1;
		btCnt_nxt = btCnt_r;
		btEn_nxt = 1'b0;
		cpuEn_nxt = 1'b0;
		rdata_nxt = rdata_r;
		btCtl_nxt[BT_CNT_CLR_BIT] = 1'b0;
		btCtl_nxt[DIV_CLR_BIT] = 1'b0;
		if (btWr) begin
			btCtl_nxt[7:2] = regReq.wdata[7:2];
		end
		if (ckWr) begin
			cpuSel_nxt = regReq.wdata[CPU_SEL_LSB +: 2];
			oscWake_nxt = regReq.wdata[OSC_WAKE_BIT];
		end
		case (sclk_bt_sel_t'(btCtl_r[BT_SEL_LSB +: 2]))
			BT_DIV4096: btEn_nxt = divTap(div_r, 12);
			BT_DIV1024: btEn_nxt = divTap(div_r, 10);
			BT_DIV128: btEn_nxt = divTap(div_r, 7);
			default: btEn_nxt = 1'b0;
		endcase
		case (sclk_cpu_sel_t'(cpuSel_r))
			CPU_DIV16: cpuEn_nxt = divTap(div_r, 4);
			CPU_DIV8: cpuEn_nxt = divTap(div_r, 3);
			CPU_DIV2: cpuEn_nxt = divTap(div_r, 1);
			default: cpuEn_nxt = 1'b1;
		endcase
		if (btEn_nxt) begin
			btCnt_nxt = btCnt_r + 1'b1;
		end
		// counter clear on write of one
		if (btWr && regReq.wdata[BT_CNT_CLR_BIT]) begin
			btCnt_nxt = '0;
			btEn_nxt = 1'b0;
		end
		// divider clear on write of one
		if (btWr && regReq.wdata[DIV_CLR_BIT]) begin
			div_nxt = '0;
			btEn_nxt = 1'b0;
		end
		wdtEn_nxt = (btCtl_nxt[7:WDT_CODE_LSB] != WDT_DISABLE_CODE);
		if (regReq.rd) begin
			case (regReq.addr)
				BASIC_TIMER_CONTROL_ADDR: rdata_nxt = btCtl_r;
				SYSTEM_CLOCK_CONTROL_ADDR: rdata_nxt = {oscWake_r, 2'b00, cpuSel_r, 3'b000};
				default: rdata_nxt = 8'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			btCtl_r <= BASIC_TIMER_CONTROL_RST;
			cpuSel_r <= CPU_DIV16;
			oscWake_r <= 1'b0;
			div_r <= '0;
			btCnt_r <= '0;
			cpuEn_r <= 1'b0;
			btEn_r <= 1'b0;
			wdtEn_r <= 1'b1;
			rdata_r <= 8'h0000;
		end else begin
			btCtl_r <= btCtl_nxt;
			cpuSel_r <= cpuSel_nxt;
			oscWake_r <= oscWake_nxt;
			div_r <= div_nxt;
			btCnt_r <= btCnt_nxt;
			cpuEn_r <= cpuEn_nxt;
			btEn_r <= btEn_nxt;
			wdtEn_r <= wdtEn_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign regRdata = rdata_r;
	assign cpuClkEn = cpuEn_r;
	assign btTickEn = btEn_r;
	assign btCount = btCnt_r;
	assign wdtEnable = wdtEn_r;

	logic [4:0] cpuGap_r, cpuGap_nxt;
	logic [4:0] cpuQuiet_r, cpuQuiet_nxt;
	logic divClr;
	assign divClr = btWr && regReq.wdata[DIV_CLR_BIT];

	always_comb begin
		cpuGap_nxt = cpuGap_r;
		cpuQuiet_nxt = cpuQuiet_r;
		if (cpuEn_r) begin
			cpuGap_nxt = 5'h00;
		end else if (cpuGap_r != 5'h1f) begin
			cpuGap_nxt = cpuGap_r + 5'h01;
		end
		if (cpuSel_r != CPU_DIV16 || divClr) begin
			cpuQuiet_nxt = 5'h00;
		end else if (cpuQuiet_r != 5'h1f) begin
			cpuQuiet_nxt = cpuQuiet_r + 5'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpuGap_r <= 5'h00;
			cpuQuiet_r <= 5'h00;
		end else begin
			cpuGap_r <= cpuGap_nxt;
			cpuQuiet_r <= cpuQuiet_nxt;
		end
	end

	a_bt_clr_zero: assert property (@(posedge core_clk) disable iff (rst)
		btWr && regReq.wdata[BT_CNT_CLR_BIT] |=> btCnt_r == '0)
		else $error("counter not cleared");
	a_bt_clr_keep: assert property (@(posedge core_clk) disable iff (rst)
		btWr && !regReq.wdata[BT_CNT_CLR_BIT] && btCnt_r != '0 && btCnt_r != '1
		|=> btCnt_r != '0)
		else $error("counter cleared by zero write");
	a_div_clr_zero: assert property (@(posedge core_clk) disable iff (rst)
		btWr && regReq.wdata[DIV_CLR_BIT] |=> div_r == '0)
		else $error("divider not cleared");
	a_strobe_self_clear: assert property (@(posedge core_clk) disable iff (rst)
		btCtl_r[1:0] == 2'b00)
		else $error("clear strobe stuck");
	a_rd_clr_zero: assert property (@(posedge core_clk) disable iff (rst)
		regReq.rd && regReq.addr == BASIC_TIMER_CONTROL_ADDR |=> regRdata[1:0] == 2'b00)
		else $error("clear strobe read back set");
	a_cpu_reset_slow: assert property (@(posedge core_clk)
		$past(rst) |-> cpuSel_r == CPU_DIV16)
		else $error("cpu rate not slowest after reset");
	a_cpu_div16_rate: assert property (@(posedge core_clk) disable iff (rst)
		cpuEn_r && cpuQuiet_r == 5'h1f |-> cpuGap_r == 5'h0f)
		else $error("cpu enable spacing wrong");
	a_cpu_div16_gap: assert property (@(posedge core_clk) disable iff (rst)
		cpuQuiet_r == 5'h1f |-> cpuGap_r <= 5'h0f)
		else $error("cpu enable missing at divide by sixteen");
	a_cpu_div2_off: assert property (@(posedge core_clk) disable iff (rst)
		cpuEn_r && cpuSel_r == CPU_DIV2 && $past(cpuSel_r) == CPU_DIV2 |=> !cpuEn_r)
		else $error("cpu enable twice in a row at divide by two");
	a_cpu_div2_on: assert property (@(posedge core_clk) disable iff (rst)
		!cpuEn_r && cpuSel_r == CPU_DIV2 && $past(cpuSel_r) == CPU_DIV2 &&
		!$past(divClr) && !$past(rst) |=> cpuEn_r)
		else $error("cpu enable missing at divide by two");
	a_cpu_full_rate: assert property (@(posedge core_clk) disable iff (rst)
		cpuSel_r == CPU_DIV1 |=> cpuEn_r)
		else $error("undivided cpu enable missing");
	a_scc_rd_sel: assert property (@(posedge core_clk) disable iff (rst)
		regReq.rd && regReq.addr == SYSTEM_CLOCK_CONTROL_ADDR
		|=> regRdata[CPU_SEL_LSB +: 2] == $past(cpuSel_r))
		else $error("cpu select read back wrong");
	a_bt_invalid_idle: assert property (@(posedge core_clk) disable iff (rst)
		btCtl_r[3:2] == 2'b11 |=> !btEn_r)
		else $error("tick on invalid code");
	a_bt_div128_tick: assert property (@(posedge core_clk) disable iff (rst)
		btCtl_r[3:2] == 2'b10 && div_r == 12'h007f && !btWr |=> btEn_r)
		else $error("div128 tick missing");
	a_bt_div1024_tick: assert property (@(posedge core_clk) disable iff (rst)
		btCtl_r[3:2] == 2'b01 && div_r[9:0] == 10'h3ff && !btWr |=> btEn_r)
		else $error("div1024 tick missing");
	a_bt_div4096_tick: assert property (@(posedge core_clk) disable iff (rst)
		btCtl_r[3:2] == 2'b00 && div_r == 12'hfff && !btWr |=> btEn_r)
		else $error("div4096 tick missing");
	a_bt_tick_count: assert property (@(posedge core_clk) disable iff (rst)
		btTickEn |-> btCount == BT_CNT_WIDTH'($past(btCount) + 8'h01))
		else $error("counter did not follow tick");
	a_wdt_code: assert property (@(posedge core_clk) disable iff (rst)
		wdtEnable == (btCtl_r[7:4] != WDT_DISABLE_CODE) || $changed(btCtl_r[7:4]))
		else $error("watchdog enable wrong");
	a_wdt_reset_on: assert property (@(posedge core_clk)
		$past(rst) |-> wdtEnable)
		else $error("watchdog not enabled after reset");
endmodule

// [src/sclk_pkg.sv]
package sclk_pkg;
	// register addresses (register addressing, upper_register_set)
	localparam logic [7:0] BASIC_TIMER_CONTROL_ADDR = 8'h00d3;
	localparam logic [7:0] SYSTEM_CLOCK_CONTROL_ADDR = 8'h00d4;
	// reset values
	localparam logic [7:0] BASIC_TIMER_CONTROL_RST = 8'h0000;
	localparam logic [7:0] SYSTEM_CLOCK_CONTROL_RST = 8'h0000;
	// basic_timer_control fields
	localparam int WDT_CODE_LSB = 4;
	localparam int BT_SEL_LSB = 2;
	localparam int BT_CNT_CLR_BIT = 1;
	localparam int DIV_CLR_BIT = 0;
	localparam logic [3:0] WDT_DISABLE_CODE = 4'h000a;
	// system_clock_control fields
	localparam int OSC_WAKE_BIT = 7;
	localparam int CPU_SEL_LSB = 3;
	localparam logic [7:0] SYSTEM_CLOCK_CONTROL_MASK = 8'h0098;
	// divider widths and ratios
	localparam int DIV_WIDTH = 12;
	localparam int BT_CNT_WIDTH = 8;

	typedef enum logic [1:0] {
		BT_DIV4096 = 2'b00,
		BT_DIV1024 = 2'b01,
		BT_DIV128 = 2'b10,
		BT_INVALID = 2'b11
	} sclk_bt_sel_t;

	typedef enum logic [1:0] {
		CPU_DIV16 = 2'b00,
		CPU_DIV8 = 2'b01,
		CPU_DIV2 = 2'b10,
		CPU_DIV1 = 2'b11
	} sclk_cpu_sel_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sclk_reg_req_t;
endpackage

// [dv/sclk_divider_ctl_test.sv]
`timescale 1ns/10ps
module sclk_divider_ctl_test;
	import sclk_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	sclk_reg_req_t regReq = '0;
	logic [7:0] regRdata;
	logic [7:0] btCount;
	logic [7:0] d;
	logic cpuClkEn;
	logic btTickEn;
	logic wdtEnable;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	int cpuDiv[4] = '{16, 8, 2, 1};
	int btDiv[3] = '{4096, 1024, 128};
	sclk_divider_ctl dut (.core_clk(core_clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
		.cpuClkEn(cpuClkEn), .btTickEn(btTickEn), .btCount(btCount), .wdtEnable(wdtEnable));
	always #2 core_clk = ~core_clk;
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk) begin
			regReq.wr <= 1'b1;
			regReq.addr <= a;
			regReq.wdata <= v;
		end
		@(posedge core_clk) regReq.wr <= 1'b0;
		@(posedge core_clk) #1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk) begin
			regReq.rd <= 1'b1;
			regReq.addr <= a;
		end
		@(posedge core_clk) regReq.rd <= 1'b0;
		#1 v = regRdata;
	endtask
	// cycles from one enable pulse to the next
	task per(input bit bt, output int p);
		int k;
		k = 0;
		while ((bt ? btTickEn : cpuClkEn) !== 1'b1 && k < 9000) begin
			@(posedge core_clk) #1;
			k++;
		end
		p = 0;
		do begin
			@(posedge core_clk) #1;
			p++;
		end while ((bt ? btTickEn : cpuClkEn) !== 1'b1 && p < 9000);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 60000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(BASIC_TIMER_CONTROL_ADDR, d);
		check("btc reset", d, BASIC_TIMER_CONTROL_RST);
		rd(SYSTEM_CLOCK_CONTROL_ADDR, d);
		check("scc reset", d, 8'h0000);
		check("wdt reset", wdtEnable, 1'b1);
		per(0, n);
		check("cpu reset div", n[15:0], 16'h0010);
		wr(SYSTEM_CLOCK_CONTROL_ADDR, 8'h00ff);
		rd(SYSTEM_CLOCK_CONTROL_ADDR, d);
		check("scc mask", d, SYSTEM_CLOCK_CONTROL_MASK);
		for (int i = 0; i < 4; i++) begin
			wr(SYSTEM_CLOCK_CONTROL_ADDR, 8'(i * 8));
			per(0, n);
			check("cpu div", n[15:0], cpuDiv[i][15:0]);
		end
		for (int i = 0; i < 3; i++) begin
			wr(BASIC_TIMER_CONTROL_ADDR, 8'(i * 4));
			per(1, n);
			check("bt div", n[15:0], btDiv[i][15:0]);
		end
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h0009);
		check("cnt kept", btCount != 8'h0000, 1'b1);
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h000a);
		check("cnt clear", btCount, 8'h0000);
		rd(BASIC_TIMER_CONTROL_ADDR, d);
		check("clear self", d, 8'h0008);
		per(1, n);
		repeat (60) @(posedge core_clk);
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h0009);
		n = 0;
		while (btTickEn !== 1'b1 && n < 300) begin
			@(posedge core_clk) #1;
			n++;
		end
		check("div clear", n > 100, 1'b1);
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h000c);
		n = 0;
		repeat (4200) begin
			@(posedge core_clk) #1;
			if (btTickEn === 1'b1) n++;
		end
		check("bt invalid", n[15:0], 16'h0000);
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h00a8);
		check("wdt off", wdtEnable, 1'b0);
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h00b8);
		check("wdt on", wdtEnable, 1'b1);
		rd(8'h00d5, d);
		check("unmapped", d, 8'h0000);
		wr(BASIC_TIMER_CONTROL_ADDR, 8'h00a0);
		@(posedge core_clk) rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(SYSTEM_CLOCK_CONTROL_ADDR, d);
		check("scc rerun", d, 8'h0000);
		check("wdt rerun", wdtEnable, 1'b1);
		final_report();
	end
endmodule
